// ---- rtl/prom_ctl_pkg.sv ----
// Package: constants and carrier types for the configuration PROM select control
package prom_ctl_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  // Revision start addresses, one per stored revision
  localparam logic [23:0] REV0_START = 24'h000000;
  localparam logic [23:0] REV1_START = 24'h040000;
  localparam logic [23:0] REV2_START = 24'h080000;
  localparam logic [23:0] REV3_START = 24'h0C0000;
  // Terminal count of the address space
  localparam logic [23:0] LAST_ADDRESS_LIMIT = 24'hFFFFFF;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  // Configuration pulse low width
  localparam int CFG_PULSE_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CFG_PULSE_CYCLES = CFG_PULSE_NS / CLK_PERIOD_NS;
  // Power-on reset hold of the output-enable/reset pin
  localparam int POR_NS = 400;
  localparam int POR_CYCLES = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] INT_REV_RESET = 2'h0;

  // Pins of the configuration link as seen by the control logic
  typedef struct packed {
    logic ce_n;
    logic oe_reset_n;
    logic busy;
    logic cfg_clk;
    logic config_pulse_pin;
    logic external_revision_pick;
    logic revision_pick_bit0;
    logic revision_pick_bit1;
  } link_in_t;

  // Programming-time options
  typedef struct packed {
    logic parallel_mode;
    logic decompress_en;
    logic use_int_osc;
    logic [1:0] int_revision;
  } prog_cfg_t;
endpackage

// ---- rtl/config_prom_select_control.sv ----
// Control logic of a configuration PROM: standby, reload pulse, revision select, cascade, busy
//
// Contract
// - While chip enable is high the block stands by, holds the counter reset and floats outputs.
// - A reload command drives the open-drain configuration pulse pin low for a pulse.
// - With all enables, a rising configuration pulse pin samples the revision and loads its start address.
// - Cascade enable goes low only with chip enable low, oe/reset high and counter past limit.
// - Cascade enable returns high as soon as oe/reset falls or chip enable rises.
// - With external pick low the revision comes from the two revision pick pins.
// - With external pick high the revision comes from the internal revision bits.
// - When external pick is low the pin value overrides the internal bits.
// - Busy is honoured only in parallel mode, ignored in serial or decompression mode.
// - Busy high in parallel mode stops the counter and holds the present data word.
// - The first rising configuration clock after busy falls presents the next address.
// - An undriven busy reads as zero so the counter is not stalled.
// - The counter advances per selected clock rise only with all enables and pulse pin high.
// - Oe/reset low holds the counter reset and floats outputs; the pin is driven low during POR.
`timescale 1ns/1ps
module config_prom_select_control #(
  parameter int ADDR_W = prom_ctl_pkg::ADDR_W,
  parameter int CFG_PULSE_CYCLES = prom_ctl_pkg::CFG_PULSE_CYCLES,
  parameter int POR_CYCLES = prom_ctl_pkg::POR_CYCLES,
  parameter int OSC_DIV = 8,
  parameter logic [ADDR_W-1:0] LAST_ADDRESS_LIMIT = ADDR_W'(prom_ctl_pkg::LAST_ADDRESS_LIMIT)
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire prom_ctl_pkg::link_in_t link_in,
  input wire prom_ctl_pkg::prog_cfg_t prog_cfg,
  input wire logic reload_cmd,
  output logic [ADDR_W-1:0] address_r,
  output logic data_oe_r,
  output logic clock_output_oe_r,
  output logic standby_r,
  output logic advance_r,
  output logic config_pulse_out_r,
  output logic config_pulse_oe_r,
  output logic oe_reset_out_r,
  output logic oe_reset_oe_r,
  output logic next_device_select_low_r,
  output logic [1:0] revision_r
);

  // Idle levels of the pins, so that no false edge is seen after reset
  localparam prom_ctl_pkg::link_in_t SYNC_IDLE = '{ce_n: 1'b1, oe_reset_n: 1'b0, busy: 1'b0,
    cfg_clk: 1'b0, config_pulse_pin: 1'b1, external_revision_pick: 1'b1,
    revision_pick_bit0: 1'b1, revision_pick_bit1: 1'b1};

  // Two-flop synchronisers for all pin inputs
  prom_ctl_pkg::link_in_t sync1_r;
  prom_ctl_pkg::link_in_t sync2_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= link_in;
      sync2_r <= sync1_r;
    end
  end

  logic ce_n_s;
  logic oe_s;
  logic busy_s;
  logic cf_s;
  assign ce_n_s = sync2_r.ce_n;
  assign oe_s = sync2_r.oe_reset_n;
  assign busy_s = sync2_r.busy;
  assign cf_s = sync2_r.config_pulse_pin;

  // Previous samples for edge detection
  logic clk_prev_r;
  logic cf_prev_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_r <= 1'b0;
      cf_prev_r <= 1'b1;
    end else begin
      clk_prev_r <= sync2_r.cfg_clk;
      cf_prev_r <= cf_s;
    end
  end

  // Internal oscillator as an enable pulse from a divider
  // The tick is a one-cycle enable, never a clock of its own
  logic [7:0] osc_cnt_r;
  logic osc_tick;
  assign osc_tick = (osc_cnt_r == 8'(OSC_DIV - 1));
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_r <= 8'h00;
    end else if (osc_tick) begin
      osc_cnt_r <= 8'h00;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  // Rise of the pin clock, seen in the same cycle it leaves the synchroniser
  logic pin_clk_rise;
  assign pin_clk_rise = sync2_r.cfg_clk & ~clk_prev_r;

  // Selected configuration clock rise: divider tick or pin clock
  logic clk_rise;
  assign clk_rise = prog_cfg.use_int_osc ? osc_tick : pin_clk_rise;

  // Revision choice: pins when external pick is low, internal bits otherwise
  logic [1:0] revision_nxt;
  always_comb begin
    if (!sync2_r.external_revision_pick) begin
      revision_nxt = {sync2_r.revision_pick_bit1, sync2_r.revision_pick_bit0};
    end else begin
      revision_nxt = prog_cfg.int_revision;
    end
  end

  // Start address table indexed by revision
  function automatic logic [ADDR_W-1:0] start_of(input logic [1:0] rev);
    logic [23:0] a;
    case (rev)
      2'h0: a = prom_ctl_pkg::REV0_START;
      2'h1: a = prom_ctl_pkg::REV1_START;
      2'h2: a = prom_ctl_pkg::REV2_START;
      default: a = prom_ctl_pkg::REV3_START;
    endcase
    return ADDR_W'(a);
  endfunction

  // Busy counts only in parallel mode without decompression
  // An undriven busy pin reads low through its pull-down
  logic busy_eff;
  assign busy_eff = busy_s & prog_cfg.parallel_mode & ~prog_cfg.decompress_en;

  // Counter may run only with chip enable low, oe/reset high and power-on hold over
  logic enabled;
  assign enabled = ~ce_n_s & oe_s & ~oe_reset_oe_r;
  // Rising configuration pulse pin; the pin is pulled up when nobody drives it
  logic cf_rise;
  assign cf_rise = cf_s & ~cf_prev_r;
  // Counter has been clocked at its last address
  logic past_limit_r;

  // Power-on reset counter; stops once the hold time has run out
  logic [15:0] por_cnt_r;
  logic por_done;
  assign por_done = (por_cnt_r == 16'(POR_CYCLES));
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt_r <= 16'h0000;
    end else if (!por_done) begin
      por_cnt_r <= por_cnt_r + 16'h0001;
    end
  end

  // Oe/reset pin pulled low until the power-on hold is over
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_reset_oe_r <= 1'b1;
    end else begin
      oe_reset_oe_r <= ~por_done;
    end
  end

  // Open-drain level of the oe/reset pin: only ever low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_reset_out_r <= 1'b0;
    end else begin
      oe_reset_out_r <= 1'b0;
    end
  end

  // Counter events; a pulse pin rise outranks a clock step
  logic load_start;
  logic step_ok;
  logic at_limit;
  assign load_start = enabled & cf_rise;
  assign step_ok = enabled & ~cf_rise & clk_rise & cf_s & ~busy_eff;
  assign at_limit = (address_r == LAST_ADDRESS_LIMIT);

  // Sampled revision, taken only on a rising configuration pulse pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      revision_r <= prom_ctl_pkg::INT_REV_RESET;
    end else if (load_start) begin
      revision_r <= revision_nxt;
    end
  end

  // Address counter: reload while disabled, start address on a pulse rise, else step
  // Busy high in parallel mode without decompression keeps step_ok low, so the address and data word are held
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_r <= ADDR_W'(prom_ctl_pkg::ADDR_RESET);
    end else if (!enabled) begin
      address_r <= start_of(revision_r);
    end else if (load_start) begin
      address_r <= start_of(revision_nxt);
    end else if (step_ok && !at_limit) begin
      address_r <= address_r + ADDR_W'(1);
    end
  end

  // Set when the counter is clocked at its last address; cleared by any reload
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      past_limit_r <= 1'b0;
    end else if (!enabled || load_start) begin
      past_limit_r <= 1'b0;
    end else if (step_ok && at_limit) begin
      past_limit_r <= 1'b1;
    end
  end

  // One-cycle pulse per accepted clock rise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      advance_r <= 1'b0;
    end else begin
      advance_r <= step_ok;
    end
  end

  // Data and clock outputs driven only while enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_oe_r <= 1'b0;
      clock_output_oe_r <= 1'b0;
    end else begin
      data_oe_r <= enabled;
      clock_output_oe_r <= enabled;
    end
  end

  // Low-power standby follows chip enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= ce_n_s;
    end
  end

  // Cascade enable to the next device
  // Registered so the next device never sees a glitch on its chip enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      next_device_select_low_r <= 1'b1;
    end else if (!enabled) begin
      next_device_select_low_r <= 1'b1;
    end else begin
      next_device_select_low_r <= ~past_limit_r;
    end
  end

  // Reload pulse on the open-drain configuration pulse pin
  // A reload request while the pulse runs is dropped
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_LOW = 2'b10
  } pulse_state_t;
  pulse_state_t pulse_state_r;
  logic [15:0] pulse_cnt_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_state_r <= PULSE_IDLE;
      pulse_cnt_r <= 16'h0000;
      config_pulse_oe_r <= 1'b0;
    end else begin
      case (pulse_state_r)
        PULSE_IDLE: begin
          if (reload_cmd) begin
            pulse_state_r <= PULSE_LOW;
            pulse_cnt_r <= 16'h0000;
            config_pulse_oe_r <= 1'b1;
          end
        end
        PULSE_LOW: begin
          if (pulse_cnt_r == 16'(CFG_PULSE_CYCLES - 1)) begin
            pulse_state_r <= PULSE_IDLE;
            config_pulse_oe_r <= 1'b0;
          end else begin
            pulse_cnt_r <= pulse_cnt_r + 16'h0001;
          end
        end
        default: begin
          pulse_state_r <= PULSE_IDLE;
          config_pulse_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain level of the configuration pulse pin: only ever low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_pulse_out_r <= 1'b0;
    end else begin
      config_pulse_out_r <= 1'b0;
    end
  end

endmodule // config_prom_select_control

// ---- bench/prom_select_monitor.sv ----
// Port checker for the PROM select control
`timescale 1ns/1ps
module prom_select_monitor #(
  parameter logic [23:0] LAST_ADDRESS_LIMIT = prom_ctl_pkg::LAST_ADDRESS_LIMIT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire prom_ctl_pkg::link_in_t link_in,
  input wire prom_ctl_pkg::prog_cfg_t prog_cfg,
  input wire logic reload_cmd,
  input wire logic [23:0] address_r,
  input wire logic data_oe_r,
  input wire logic clock_output_oe_r,
  input wire logic standby_r,
  input wire logic advance_r,
  input wire logic config_pulse_out_r,
  input wire logic config_pulse_oe_r,
  input wire logic oe_reset_out_r,
  input wire logic oe_reset_oe_r,
  input wire logic next_device_select_low_r,
  input wire logic [1:0] revision_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Reload pulse: four low cycles, then the pin is let go
  sequence pulse_s;
    config_pulse_oe_r [*4] ##1 !config_pulse_oe_r;
  endsequence
  AST_STANDBY: assert property (link_in.ce_n [*4] |-> standby_r && !data_oe_r
    && !clock_output_oe_r) else $error("standby outputs wrong");
  AST_OFF: assert property ((link_in.ce_n || !link_in.oe_reset_n) [*4]
    |-> next_device_select_low_r && !data_oe_r) else $error("outputs not released");
  AST_CASCADE: assert property ($fell(next_device_select_low_r)
    |-> address_r == LAST_ADDRESS_LIMIT) else $error("early cascade");
  AST_PULSE: assert property ($rose(config_pulse_oe_r) |-> pulse_s)
    else $error("pulse width wrong");
  AST_RELOAD: assert property (reload_cmd && !config_pulse_oe_r |=> config_pulse_oe_r)
    else $error("reload gave no pulse");
  AST_OPEN_DRAIN: assert property (!config_pulse_out_r && !oe_reset_out_r)
    else $error("open drain level high");
  AST_STALL: assert property ((prog_cfg.parallel_mode && !prog_cfg.decompress_en
    && link_in.busy) [*4] |-> !advance_r) else $error("advance while busy");
  AST_STEP: assert property (advance_r |-> address_r == $past(address_r) + 24'h1
    || address_r == LAST_ADDRESS_LIMIT) else $error("bad step");
  AST_REV: assert property ($rose(link_in.config_pulse_pin) |-> ##5 revision_r ==
    (link_in.external_revision_pick ? prog_cfg.int_revision
    : {link_in.revision_pick_bit1, link_in.revision_pick_bit0})) else $error("bad rev");
  AST_POR: assert property ($rose(reset_n) |-> oe_reset_oe_r [*4])
    else $error("power-on hold short");
endmodule // prom_select_monitor

// ---- bench/fpga_side_model.sv ----
// FPGA side: configuration clock, busy and pulled-up pulse pin
`timescale 1ns/1ps
module fpga_side_model (
  input wire logic core_clk,
  input wire logic pulse_oe,
  output logic cfg_clk,
  output wire logic busy,
  output wire logic cf_pin
);
  logic busy_v = 1'b0;
  logic busy_en = 1'b1;
  initial cfg_clk = 1'b0;
  // Pull-up wins unless the PROM pulls low
  assign cf_pin = pulse_oe ? 1'b0 : 1'b1;
  // Busy floats when the FPGA lets go of it
  assign busy = busy_en ? busy_v : 1'bz;
  // Clock rises four core cycles apart, stands low between
  task automatic tick(input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk);
      #1 cfg_clk = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 cfg_clk = 1'b0;
    end
  endtask
endmodule // fpga_side_model

// ---- bench/config_prom_select_control_bench.sv ----
// Self-checking bench for the PROM select control
`timescale 1ns/1ps
module config_prom_select_control_bench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reload_cmd = 1'b0;
  logic ce_n = 1'b1;
  logic oe_drv = 1'b1;
  logic [2:0] pick = 3'h0;
  prom_ctl_pkg::prog_cfg_t prog_cfg = '0;
  prom_ctl_pkg::link_in_t link_in;
  tri0 busy_w;
  wire cfg_clk_w;
  wire cf_w;
  logic [23:0] address_r;
  logic data_oe_r, clock_output_oe_r, standby_r, advance_r, config_pulse_out_r;
  logic config_pulse_oe_r, oe_reset_out_r, oe_reset_oe_r, next_device_select_low_r;
  logic [1:0] revision_r;
  int err_count = 0;
  int samples_checked = 0;
  // Counter limit kept small so that the cascade output is reached
  localparam logic [23:0] LIMIT = prom_ctl_pkg::REV1_START + 24'h000009;
  localparam logic [23:0] STARTS [4] = '{prom_ctl_pkg::REV0_START,
    prom_ctl_pkg::REV1_START, prom_ctl_pkg::REV2_START, prom_ctl_pkg::REV3_START};
  // Pins as the PROM sees them; oe/reset is open drain
  assign link_in = {ce_n, oe_drv & !oe_reset_oe_r, busy_w, cfg_clk_w, cf_w, pick};
  config_prom_select_control #(
    .CFG_PULSE_CYCLES(4),
    .POR_CYCLES(4),
    .LAST_ADDRESS_LIMIT(LIMIT)
  ) dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .link_in(link_in),
    .prog_cfg(prog_cfg),
    .reload_cmd(reload_cmd),
    .address_r(address_r),
    .data_oe_r(data_oe_r),
    .clock_output_oe_r(clock_output_oe_r),
    .standby_r(standby_r),
    .advance_r(advance_r),
    .config_pulse_out_r(config_pulse_out_r),
    .config_pulse_oe_r(config_pulse_oe_r),
    .oe_reset_out_r(oe_reset_out_r),
    .oe_reset_oe_r(oe_reset_oe_r),
    .next_device_select_low_r(next_device_select_low_r),
    .revision_r(revision_r)
  );
  fpga_side_model fpga (.core_clk(core_clk), .pulse_oe(config_pulse_oe_r),
    .cfg_clk(cfg_clk_w), .busy(busy_w), .cf_pin(cf_w));
  // Clock and watchdog
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #100us;
    err_count++;
    report_and_stop();
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reload(input logic ext, input logic [1:0] r);
    pick = {ext, r[0], r[1]};
    reload_cmd = 1'b1;
    cyc(1);
    reload_cmd = 1'b0;
    chk("pulse drive", 24'h1, 24'(config_pulse_oe_r));
    cyc(3);
    chk("pulse drive", 24'h1, 24'(config_pulse_oe_r));
    cyc(1);
    chk("pulse drive", 24'h0, 24'(config_pulse_oe_r));
    cyc(10);
  endtask
  task automatic step_chk(input int n, input logic [23:0] exp);
    fpga.tick(n);
    cyc(5);
    chk("address", exp, address_r);
  endtask
  task automatic test_standby();
    step_chk(2, STARTS[0]);
    chk("standby", 24'h1, 24'(standby_r));
    chk("clock enable", 24'h0, 24'(clock_output_oe_r));
    chk("data enable", 24'h0, 24'(data_oe_r));
    ce_n = 1'b0;
    cyc(6);
    chk("data enable", 24'h1, 24'(data_oe_r));
    chk("standby", 24'h0, 24'(standby_r));
    $display("standby test done");
  endtask
  task automatic test_revs();
    for (int r = 0; r < 4; r++) begin
      do_reload(1'b0, r[1:0]);
      chk("revision", 24'(r), 24'(revision_r));
      chk("start", STARTS[r], address_r);
    end
    prog_cfg.int_revision = 2'h1;
    do_reload(1'b1, 2'h2);
    chk("revision", 24'h1, 24'(revision_r));
    chk("start", STARTS[1], address_r);
    $display("revision test done");
  endtask
  task automatic test_count();
    step_chk(3, STARTS[1] + 24'h3);
    prog_cfg.parallel_mode = 1'b1;
    fpga.busy_v = 1'b1;
    cyc(3);
    step_chk(2, STARTS[1] + 24'h3);
    fpga.busy_v = 1'b0;
    cyc(3);
    step_chk(1, STARTS[1] + 24'h4);
    fpga.busy_v = 1'b1;
    prog_cfg.decompress_en = 1'b1;
    step_chk(1, STARTS[1] + 24'h5);
    prog_cfg = '{parallel_mode: 1'b0, decompress_en: 1'b0, use_int_osc: 1'b0,
      int_revision: 2'h1};
    step_chk(1, STARTS[1] + 24'h6);
    prog_cfg.parallel_mode = 1'b1;
    fpga.busy_en = 1'b0;
    cyc(3);
    step_chk(1, STARTS[1] + 24'h7);
    chk("cascade", 24'h1, 24'(next_device_select_low_r));
    step_chk(2, LIMIT);
    chk("cascade", 24'h1, 24'(next_device_select_low_r));
    step_chk(1, LIMIT);
    chk("cascade", 24'h0, 24'(next_device_select_low_r));
    $display("count test done");
  endtask
  task automatic test_oe();
    oe_drv = 1'b0;
    cyc(6);
    chk("data enable", 24'h0, 24'(data_oe_r));
    chk("clock enable", 24'h0, 24'(clock_output_oe_r));
    chk("cascade", 24'h1, 24'(next_device_select_low_r));
    chk("address", STARTS[1], address_r);
    oe_drv = 1'b1;
    $display("oe test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(10);
    reset_n = 1'b1;
    cyc(1);
    chk("oe hold", 24'h1, 24'(oe_reset_oe_r));
    cyc(9);
    chk("oe hold", 24'h0, 24'(oe_reset_oe_r));
    test_standby();
    test_revs();
    test_count();
    test_oe();
    report_and_stop();
  end
endmodule // config_prom_select_control_bench
bind config_prom_select_control prom_select_monitor #(
  .LAST_ADDRESS_LIMIT(LAST_ADDRESS_LIMIT)
) mon (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .link_in(link_in),
  .prog_cfg(prog_cfg),
  .reload_cmd(reload_cmd),
  .address_r(address_r),
  .data_oe_r(data_oe_r),
  .clock_output_oe_r(clock_output_oe_r),
  .standby_r(standby_r),
  .advance_r(advance_r),
  .config_pulse_out_r(config_pulse_out_r),
  .config_pulse_oe_r(config_pulse_oe_r),
  .oe_reset_out_r(oe_reset_out_r),
  .oe_reset_oe_r(oe_reset_oe_r),
  .next_device_select_low_r(next_device_select_low_r),
  .revision_r(revision_r)
);
